/* File: hdl/spi_regs.vh */
`ifndef SPI_REGS_VH
`define SPI_REGS_VH
// Register addresses on the local port
`define ADDR_STAT 2'h0
`define ADDR_CTL1 2'h1
`define ADDR_CTL2 2'h2
`define ADDR_BUF 2'h3
// Status register bits
`define STAT_EN 15
`define STAT_IDLE 13
`define STAT_OVF 6
`define STAT_TXF 1
`define STAT_RXF 0
// Control register one bits
`define C1_CLK_OFF 12
`define C1_DOUT_OFF 11
`define C1_WIDTH 10
`define C1_SAMPLE 9
`define C1_EDGE 8
`define C1_SEL_EN 7
`define C1_POL 6
`define C1_MASTER 5
`define C1_SEC_HI 4
`define C1_SEC_LO 2
`define C1_PRI_HI 1
`define C1_PRI_LO 0
`define C1_MASK 16'h1fff
// Control register two bits
`define C2_FRAMED 15
`define C2_FDIR 14
`define C2_FPOL 13
`define C2_FEDGE 1
`define C2_MASK 16'he002
`define CTL_RESET 16'h0000
// Word lengths in bits
`define CNT_WORD 5'h10
`define CNT_BYTE 5'h08
// Primary divide factors for codes 0 to 3
`define PRI_DIV0 10'h040
`define PRI_DIV1 10'h010
`define PRI_DIV2 10'h004
`define PRI_DIV3 10'h001
// Secondary divide is this base minus the code
`define SEC_BASE 10'h008
// Half periods spent on a preceding frame pulse
`define PRE_HALVES 6'h02
`endif

/* File: hdl/spi_master_slave_framed.v */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "spi_regs.vh"
module spi_master_slave_framed (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire idle_mode,
  input wire [1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output wire serial_out_oe,
  input wire shift_clock_pin_in,
  output wire shift_clock_pin_out,
  output wire shift_clock_pin_oe,
  input wire slave_select_n_in,
  output wire slave_select_n_out,
  output wire slave_select_n_oe
);

  reg module_enable;
  reg idle_stop;
  reg receive_overflow;
  reg tx_full;
  reg rx_full;
  reg [15:0] ctl_one;
  reg [15:0] ctl_two;
  reg [15:0] transmit_buffer;
  reg [15:0] receive_buffer;
  reg [15:0] shift_reg;
  reg [15:0] rx_shift;
  reg busy;
  reg pre;
  reg [5:0] tick;
  reg [4:0] samples;
  reg [9:0] div;
  reg sck_act;
  reg frame_act;
  reg frame_seen;
  reg [2:0] sck_sync;
  reg [1:0] sdi_sync;
  reg [1:0] ss_sync;

  wire clock_out_disable = ctl_one[`C1_CLK_OFF];
  wire data_out_disable = ctl_one[`C1_DOUT_OFF];
  wire word_width_sel = ctl_one[`C1_WIDTH];
  wire sample_phase = ctl_one[`C1_SAMPLE];
  wire clock_edge = ctl_one[`C1_EDGE];
  wire select_enable = ctl_one[`C1_SEL_EN];
  wire clock_polarity = ctl_one[`C1_POL];
  wire master_select = ctl_one[`C1_MASTER];
  wire [2:0] secondary_prescale = ctl_one[`C1_SEC_HI:`C1_SEC_LO];
  wire [1:0] primary_prescale = ctl_one[`C1_PRI_HI:`C1_PRI_LO];
  wire framed_enable = ctl_two[`C2_FRAMED];
  wire frame_direction = ctl_two[`C2_FDIR];
  wire frame_polarity = ctl_two[`C2_FPOL];
  wire frame_edge = ctl_two[`C2_FEDGE];

  wire run = clk_en & module_enable & ~(idle_stop & idle_mode);

  // Synchronised pin levels
  wire sck_s = sck_sync[1];
  wire sck_q = sck_sync[2];
  wire sdi_s = sdi_sync[1];
  wire ss_s = ss_sync[1];

  reg [9:0] pri_div;
  always @* begin
    case (primary_prescale)
      2'h0: pri_div = `PRI_DIV0;
      2'h1: pri_div = `PRI_DIV1;
      2'h2: pri_div = `PRI_DIV2;
      default: pri_div = `PRI_DIV3;
    endcase
  end
  wire [9:0] sec_div = `SEC_BASE - {7'h00, secondary_prescale};
  wire [19:0] prod_full = pri_div * sec_div;
  // Half period in system clocks; the compare stops one short of it
  wire [9:0] half_period = prod_full[9:0];
  wire div_hit = (div == half_period - 10'h001);

  wire [4:0] word_bits = word_width_sel ? `CNT_WORD : `CNT_BYTE;
  wire edge_eff = clock_edge & ~framed_enable;
  // sample phase only counts for a master
  wire smp_eff = sample_phase & master_select;
  // Frame sync direction decoded once for both roles
  wire frame_out_mode = framed_enable & ~frame_direction;
  wire frame_in_mode = framed_enable & frame_direction;
  wire frame_pulse_in = frame_polarity ? ss_s : ~ss_s;

  // Master end tick: one extra half period for end sampling while edge_eff is clear
  wire [5:0] end_tick = {word_bits, 1'b0} +
    {5'h00, smp_eff & ~edge_eff};
  wire [5:0] t_next = tick + 6'h01;

  // Slave edge detection on the sampled shift clock
  wire sck_edge = sck_s ^ sck_q;
  wire slv_lead = sck_s ^ clock_polarity;
  wire slv_sel = framed_enable ? (frame_seen | frame_pulse_in) :
    (select_enable ? ~ss_s : 1'b1);

  wire m_step = master_select & busy & ~pre & div_hit;
  wire s_step = ~master_select & slv_sel & sck_edge;
  wire step = run & (m_step | s_step);
  wire is_lead = master_select ? t_next[0] : slv_lead;
  wire is_change = edge_eff ? ~is_lead : is_lead;
  wire first = (tick == 6'h00);
  // sample at end or middle of output time
  wire do_sample = smp_eff ? (is_change & ~first) : ~is_change;
  wire do_shift = is_change & ~first;
  wire [4:0] next_samples = samples + 5'h01;
  wire [15:0] next_rx = {rx_shift[14:0], sdi_s};
  wire m_done = m_step & (t_next == end_tick);
  wire s_done = s_step & do_sample & (next_samples == word_bits);
  wire done = run & (m_done | s_done);
  wire [15:0] rx_word = word_width_sel ? next_rx : {8'h00, next_rx[7:0]};
  wire rx_sampled_last = do_sample & step;
  // Last bit may land in the same cycle as the done strobe
  wire [15:0] done_word = rx_sampled_last ? rx_word :
    (word_width_sel ? rx_shift : {8'h00, rx_shift[7:0]});

  // start when tx word waits and shifter idles
  // Framed input mode also waits for the sync pulse
  wire m_start = master_select & ~busy & tx_full &
    (~frame_in_mode | frame_seen | frame_pulse_in);
  wire s_load = ~master_select & first & tx_full;
  wire load = run & (m_start | s_load);
  // select released mid-word restarts the word
  wire slv_abort = ~master_select & ~framed_enable & select_enable & ss_s;

  // Buffer accesses freeze with the clock enable
  wire buf_wr = clk_en & wr & (addr == `ADDR_BUF);
  wire buf_rd = clk_en & rd & (addr == `ADDR_BUF);

  // First bit on the wire: bit 15 or bit 7
  function out_msb;
    input [15:0] w;
    input m16;
    begin
      out_msb = m16 ? w[15] : w[7];
    end
  endfunction

  // Two-stage input synchronisers
  always @(posedge clk_sys) begin
    if (rst) begin
      sck_sync <= 3'h0;
      sdi_sync <= 2'h0;
      // Select idles high, so no false frame follows reset
      ss_sync <= 2'h3;
    end else if (clk_en) begin
      sck_sync <= {sck_sync[1:0], shift_clock_pin_in};
      sdi_sync <= {sdi_sync[0], serial_in_pin};
      ss_sync <= {ss_sync[0], slave_select_n_in};
    end
  end

  // Software-written controls
  always @(posedge clk_sys) begin
    if (rst) begin
      module_enable <= 1'b0;
      idle_stop <= 1'b0;
      ctl_one <= `CTL_RESET;
      ctl_two <= `CTL_RESET;
      transmit_buffer <= `CTL_RESET;
    end else if (clk_en && wr) begin
      case (addr)
        `ADDR_STAT: begin
          module_enable <= wdata[`STAT_EN];
          idle_stop <= wdata[`STAT_IDLE];
        end
        `ADDR_CTL1: ctl_one <= wdata & `C1_MASK;
        `ADDR_CTL2: ctl_two <= wdata & `C2_MASK;
        default: transmit_buffer <= wdata;
      endcase
    end
  end

  // Status flags; hardware sets win over clears
  always @(posedge clk_sys) begin
    if (rst) begin
      tx_full <= 1'b0;
      rx_full <= 1'b0;
      receive_overflow <= 1'b0;
      receive_buffer <= `CTL_RESET;
    end else begin
      // tx full set on write, cleared on load
      if (buf_wr)
        tx_full <= 1'b1;
      else if (load)
        tx_full <= 1'b0;
      // rx full set on transfer, cleared on read
      if (done && rx_full && !buf_rd) begin
        receive_overflow <= 1'b1;
      end else if (done) begin
        rx_full <= 1'b1;
        receive_buffer <= done_word;
      end else if (buf_rd) begin
        rx_full <= 1'b0;
      end
      // Writing zero to bit 6 clears overflow; a new overflow wins
      if (clk_en && wr && addr == `ADDR_STAT && !wdata[`STAT_OVF] &&
          !(done && rx_full && !buf_rd))
        receive_overflow <= 1'b0;
    end
  end

  // Read data one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      rdata <= `CTL_RESET;
    end else if (clk_en && rd) begin
      case (addr)
        // Unused status bits read as zero
        `ADDR_STAT: rdata <= {module_enable, 1'b0, idle_stop, 6'h00,
          receive_overflow, 4'h0, tx_full, rx_full};
        `ADDR_CTL1: rdata <= ctl_one;
        `ADDR_CTL2: rdata <= ctl_two;
        default: rdata <= receive_buffer;
      endcase
    end
  end

  // half-period divider for the master clock
  always @(posedge clk_sys) begin
    if (rst) begin
      div <= 10'h000;
    end else if (run) begin
      // Divider rests at zero between words
      if (!busy || div_hit)
        div <= 10'h000;
      else
        div <= div + 10'h001;
    end
  end

  // Frame pulse seen on the select pin
  always @(posedge clk_sys) begin
    if (rst) begin
      frame_seen <= 1'b0;
    end else if (run) begin
      if (done || !frame_in_mode)
        frame_seen <= 1'b0;
      // select pin as frame sync input
      else if (frame_pulse_in)
        frame_seen <= 1'b1;
    end else if (clk_en && !module_enable) begin
      // Disabled block forgets any pending frame pulse
      frame_seen <= 1'b0;
    end
  end

  // Transfer engine
  always @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      pre <= 1'b0;
      tick <= 6'h00;
      samples <= 5'h00;
      sck_act <= 1'b0;
      frame_act <= 1'b0;
      shift_reg <= `CTL_RESET;
      rx_shift <= `CTL_RESET;
      serial_out_pin <= 1'b0;
    end else if (clk_en && !module_enable) begin
      busy <= 1'b0;
      pre <= 1'b0;
      tick <= 6'h00;
      samples <= 5'h00;
      sck_act <= 1'b0;
      frame_act <= 1'b0;
    end else if (run) begin
      if (load) begin
        // word moves into the shift register
        shift_reg <= transmit_buffer;
        serial_out_pin <= out_msb(transmit_buffer, word_width_sel);
        // A slave never goes busy; it follows the far clock
        busy <= master_select;
        tick <= 6'h00;
        samples <= 5'h00;
        pre <= master_select & frame_out_mode & ~frame_edge;
        frame_act <= master_select & frame_out_mode;
      end else if (slv_abort) begin
        tick <= 6'h00;
        samples <= 5'h00;
      end else if (master_select && busy && pre && div_hit) begin
        // pulse spans two half periods before clocking
        tick <= t_next;
        if (t_next == `PRE_HALVES) begin
          pre <= 1'b0;
          tick <= 6'h00;
          frame_act <= 1'b0;
        end
      end else if (step) begin
        tick <= t_next;
        // exactly one clock period per bit
        if (master_select && t_next <= {word_bits, 1'b0})
          sck_act <= ~sck_act;
        if (master_select && t_next == `PRE_HALVES)
          frame_act <= 1'b0;
        if (do_shift) begin
          shift_reg <= {shift_reg[14:0], 1'b0};
          serial_out_pin <= out_msb({shift_reg[14:0], 1'b0},
            word_width_sel);
        end
        if (do_sample) begin
          rx_shift <= next_rx;
          samples <= next_samples;
        end
        // word complete: the flag process takes it
        if (done) begin
          busy <= 1'b0;
          tick <= 6'h00;
          samples <= 5'h00;
        end
      end
    end
  end

  // Pin drive
  // four serial pins: data in, data out, clock, select
  // clock out only in master mode
  assign shift_clock_pin_oe = module_enable & master_select &
    ~clock_out_disable;
  assign shift_clock_pin_out = sck_act ^ clock_polarity;
  assign serial_out_oe = module_enable & ~data_out_disable;
  assign slave_select_n_oe = module_enable & master_select &
    frame_out_mode;
  assign slave_select_n_out = frame_polarity ? frame_act : ~frame_act;

endmodule

/* File: tb/spi_checker_sva.sv */
`timescale 1ns/10ps
module spi_checker (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire idle_mode,
  input wire [1:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire serial_out_pin,
  input wire serial_out_oe,
  input wire shift_clock_pin_out,
  input wire shift_clock_pin_oe,
  input wire slave_select_n_oe
);
  reg [15:0] st, c1, c2;
  wire en = st[15];
  wire ren = rd && clk_en;
  wire wen = wr && clk_en;
  // Shadow of the written control bits
  always @(posedge clk_sys) begin
    if (rst) begin
      st <= 16'h0000;
      c1 <= 16'h0000;
      c2 <= 16'h0000;
    end else if (wen) begin
      if (addr == 2'h0)
        st <= wdata;
      if (addr == 2'h1)
        c1 <= wdata & 16'h1fff;
      if (addr == 2'h2)
        c2 <= wdata & 16'he002;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_sck_oe;
    shift_clock_pin_oe == (en && c1[5] && !c1[12]);
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("sck oe");
  property p_sdo_off;
    !en || c1[11] |-> !serial_out_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo oe");
  property p_fs_oe;
    slave_select_n_oe |-> en && c1[5] && c2[15] && !c2[14];
  endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("fs oe");
  property p_rd_ctl;
    ren && (addr == 2'h1 || addr == 2'h2)
      |=> rdata == ($past(addr) == 2'h1 ? c1 : c2);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("ctl read");
  property p_rd_st;
    ren && addr == 2'h0 |=> rdata[15:13] == {en, 1'b0, st[13]};
  endproperty
  a_rd_st: assert property (p_rd_st) else $error("stat read");
  property p_txf;
    wen && addr == 2'h3 ##1 ren && addr == 2'h0 |=> rdata[1];
  endproperty
  a_txf: assert property (p_txf) else $error("tx full");
  property p_rxf;
    ren && addr == 2'h3 ##1 ren && addr == 2'h0 |=> !rdata[0];
  endproperty
  a_rxf: assert property (p_rxf) else $error("rx full");
  property p_halt;
    (en && st[13] && idle_mode && clk_en && !wr) [*3]
      |-> $stable(shift_clock_pin_out) && $stable(serial_out_pin);
  endproperty
  a_halt: assert property (p_halt) else $error("idle halt");
  c_fs: cover property (slave_select_n_oe);
  c_slave: cover property (en && !c1[5] && ren && addr == 2'h3);
  c_halt: cover property (en && st[13] && idle_mode);
endmodule

/* File: tb/spi_peer.sv */
`timescale 1ns/10ps
module spi_peer (
  input wire sclk,
  input wire mosi,
  output wire miso
);
  reg pol = 1'b0, edg = 1'b0, w16 = 1'b0;
  reg [15:0] tx = 16'h0000, rx = 16'h0000;
  integer n = 0;
  realtime t0 = 0.0, half = 0.0;
  assign miso = w16 ? tx[15] : tx[7];
  task load(input p, input e, input w, input [15:0] v);
    begin
      pol = p;
      edg = e;
      w16 = w;
      tx = v;
      n = 0;
    end
  endtask
  // Sample on one clock edge, shift out on the other
  always @(sclk) begin
    half = $realtime - t0;
    t0 = $realtime;
    if ((sclk ^ pol) == edg) begin
      rx = {rx[14:0], mosi};
      n = n + 1;
    end else if (n > 0)
      tx = {tx[14:0], ~tx[0]};
  end
endmodule

/* File: tb/spi_master_slave_framed_tb_top.sv */
`timescale 1ns/10ps
`include "spi_regs.vh"
module spi_master_slave_framed_tb_top;
  reg clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, idle_mode = 1'b0;
  reg wr = 1'b0, rd = 1'b0, sdi = 1'b0, sck_in = 1'b0, ss_in = 1'b1;
  reg slv = 1'b0, rd_d = 1'b0, fs = 1'b0;
  reg [1:0] addr = 2'h0;
  reg [15:0] wdata = 16'h0000, d, r, r1, m;
  reg [15:0] expq[$];
  reg [7:0] q;
  wire [15:0] rdata;
  wire sdo, sck, ss_out, ss_oe, miso;
  integer failures = 0, n_tests = 0, i;
  always #5 clk_sys = ~clk_sys;
  spi_master_slave_framed dut_u (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .idle_mode(idle_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_in_pin(slv ? sdi : miso), .serial_out_pin(sdo),
    .serial_out_oe(), .shift_clock_pin_in(sck_in),
    .shift_clock_pin_out(sck), .shift_clock_pin_oe(),
    .slave_select_n_in(ss_in), .slave_select_n_out(ss_out),
    .slave_select_n_oe(ss_oe));
  spi_peer peer_u (.sclk(sck), .mosi(sdo), .miso(miso));
  task chk(input [95:0] nm, input [15:0] e, input [15:0] s);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wreg(input [1:0] a, input [15:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rchk(input [1:0] a, input [15:0] e, input more);
    begin
      addr <= a;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge clk_sys);
      if (!more) begin
        rd <= 1'b0;
        @(posedge clk_sys);
      end
    end
  endtask
  task pwait(input [15:0] nb, input [15:0] v);
    begin
      for (i = 0; i < 4000 && peer_u.n < nb; i = i + 1)
        @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      chk("peer_rx", v & m, peer_u.rx & m);
      chk("bits", nb, peer_u.n[15:0]);
      chk("half_ns", 16'h0050, 16'($rtoi(peer_u.half)));
    end
  endtask
  task send(input [15:0] c1v, input [15:0] c2v);
    begin
      m = c1v[10] ? 16'hffff : 16'h00ff;
      d = $urandom;
      r = $urandom;
      wreg(`ADDR_CTL2, c2v);
      wreg(`ADDR_CTL1, c1v);
      wreg(`ADDR_BUF, d);
      peer_u.load(c1v[6], c1v[8], c1v[10], r);
      pwait(c1v[10] ? 16'h0010 : 16'h0008, d);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    rd_d <= rd && clk_en;
    if (ss_oe && !ss_out)
      fs <= 1'b1;
    if (rd_d)
      chk("rdata", expq.pop_front(), rdata);
  end
  initial begin
    #400000;
    failures = failures + 1;
    results;
  end
  initial begin
    d = $urandom(92);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk(`ADDR_CTL1, 16'h0000, 0);
    wreg(`ADDR_STAT, 16'hffff);
    rchk(`ADDR_STAT, 16'ha000, 0);
    wreg(`ADDR_STAT, 16'h0000);
    wreg(`ADDR_CTL1, 16'hfffe);
    rchk(`ADDR_CTL1, 16'h1ffe, 0);
    wreg(`ADDR_CTL2, 16'hffff);
    rchk(`ADDR_CTL2, 16'he002, 0);
    $display("t1 registers done");
    wreg(`ADDR_STAT, 16'h8000);
    // framed: edge and select-enable bits kept clear
    send(16'h003a, 16'h8000);
    chk("fsync", 16'h0001, {15'h0000, fs});
    rchk(`ADDR_BUF, r & m, 0);
    $display("t2 framed byte done");
    send(16'h077a, 16'h0000);
    rchk(`ADDR_BUF, r, 0);
    $display("t3 word mode done");
    send(16'h003a, 16'h0000);
    r1 = r;
    send(16'h003a, 16'h0000);
    rchk(`ADDR_STAT, 16'h8041, 0);
    wreg(`ADDR_STAT, 16'h8000);
    rchk(`ADDR_STAT, 16'h8001, 0);
    rchk(`ADDR_BUF, r1 & 16'h00ff, 0);
    $display("t4 overflow done");
    wreg(`ADDR_CTL1, 16'h043a);
    wreg(`ADDR_STAT, 16'ha000);
    idle_mode <= 1'b1;
    m = 16'hffff;
    peer_u.load(1'b0, 1'b0, 1'b1, 16'hc3a5);
    addr <= `ADDR_BUF;
    wdata <= 16'h3c5a;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rchk(`ADDR_STAT, 16'ha002, 0);
    repeat (60) @(posedge clk_sys);
    rchk(`ADDR_STAT, 16'ha002, 0);
    idle_mode <= 1'b0;
    repeat (40) @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    clk_en <= 1'b1;
    pwait(16'h0010, 16'h3c5a);
    rchk(`ADDR_BUF, 16'hc3a5, 1);
    rchk(`ADDR_STAT, 16'ha000, 0);
    $display("t5 idle stop done");
    wreg(`ADDR_STAT, 16'h0000);
    wreg(`ADDR_CTL1, 16'h0000);
    wreg(`ADDR_STAT, 16'h8000);
    r = $urandom;
    wreg(`ADDR_BUF, r);
    slv <= 1'b1;
    ss_in <= 1'b0;
    d = $urandom;
    #3;
    // far party drives the shift clock
    for (i = 7; i >= 0; i = i - 1) begin
      #62.5;
      sck_in = 1'b1;
      sdi = d[i];
      #62.5 q = {q[6:0], sdo};
      sck_in = 1'b0;
    end
    repeat (20) @(posedge clk_sys);
    chk("slave_out", r & 16'h00ff, {8'h00, q});
    rchk(`ADDR_STAT, 16'h8001, 0);
    rchk(`ADDR_BUF, d & 16'h00ff, 0);
    $display("t6 slave done");
    results;
  end
endmodule
bind spi_master_slave_framed spi_checker chk_u (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .idle_mode(idle_mode),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .shift_clock_pin_out(shift_clock_pin_out),
  .shift_clock_pin_oe(shift_clock_pin_oe),
  .slave_select_n_oe(slave_select_n_oe));
